// ===== design/btof_watchdog.sv
// Notes on behaviour
// - The timeout threshold is the time base element 4 multiplied by the multiplier element 5.
// - The multiplier element is read/write, holds 0 to 255 and is 0 after reset.
// - If the time base or the multiplier is zero, no timeout error is ever raised.
// - The ten newest error codes are kept in storage that survives power-off.
// - History slots never written since the module was new read as zero.
// - Element 10 holds the newest error code and element 19 the oldest, in age order between.
// - History elements are read-only 8-bit codes and software must not write them.
// - History codes use bit 1 for output fault, bit 2 for bus timeout, bit 7 for buffer overflow, others reserved.
// - The failsafe mode element selects per output whether a timeout keeps the level or applies the failsafe level.
// - The failsafe level element gives per output the level applied on timeout, 0 clears and 1 sets.
// - The timeout error bit rises when the bus traffic gap exceeds the threshold.
// - The time base element is read/write, 0 to 255 milliseconds.
// - Elements are reached by writing the index register and then accessing the value register.
`include "btof_defs.svh"

module btof_watchdog #(
    parameter int MS_CYCLES = `BTOF_MS_CYCLES
) (
    // Clock and resets.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic lifetime_init_i,
    // Register port from the controller.
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Error sources and output path.
    input wire logic err_output_fault_i,
    input wire logic err_buf_overflow_i,
    input wire logic [7:0] out_req_i,
    output logic [7:0] out_o,
    output logic comm_timeout_o
);

    localparam int TICK_W = $clog2(MS_CYCLES + 1);

    // Returns true when an element index falls in the history range.
    function automatic logic is_hist(input logic [7:0] idx);
        is_hist = (idx >= `BTOF_EL_HIST_FIRST) && (idx <= `BTOF_EL_HIST_LAST);
    endfunction

    btof_pkg::btof_byte_t index_reg, index_next;
    btof_pkg::btof_byte_t tbase_reg, tbase_next;
    btof_pkg::btof_byte_t mult_reg, mult_next;
    btof_pkg::btof_byte_t mode_reg, mode_next;
    btof_pkg::btof_byte_t level_reg, level_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic [7:0] hist_rd;
    logic [3:0] hist_sel;
    logic wr_value;
    logic bus_access;

    // Any register access counts as bus traffic from the controller.
    assign bus_access = reg_wr_i | reg_rd_i;
    assign wr_value = reg_wr_i && (reg_addr_i == `BTOF_REG_VALUE);
    assign hist_sel = 4'(index_reg - `BTOF_EL_HIST_FIRST);

    // Register writes: index register, then value register at the selected element.
    always_comb begin
        index_next = index_reg;
        tbase_next = tbase_reg;
        mult_next = mult_reg;
        mode_next = mode_reg;
        level_next = level_reg;
        if (reg_wr_i && (reg_addr_i == `BTOF_REG_INDEX)) begin
            index_next = reg_wdata_i;
        end
        if (wr_value && !is_hist(index_reg)) begin
            case (index_reg)
                `BTOF_EL_TIME_BASE: tbase_next = reg_wdata_i;
                `BTOF_EL_MULTIPLIER: mult_next = reg_wdata_i;
                `BTOF_EL_FS_MODE: mode_next = reg_wdata_i;
                `BTOF_EL_FS_LEVEL: level_next = reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Read answer registered one cycle after the read strobe.
    always_comb begin
        rdata_next = rdata_reg;
        rvalid_next = reg_rd_i;
        if (reg_rd_i) begin
            rdata_next = 8'h00;
            if (reg_addr_i == `BTOF_REG_INDEX) begin
                rdata_next = index_reg;
            end else if (reg_addr_i == `BTOF_REG_VALUE) begin
                if (is_hist(index_reg)) begin
                    rdata_next = hist_rd;
                end else begin
                    case (index_reg)
                        `BTOF_EL_TIME_BASE: rdata_next = tbase_reg;
                        `BTOF_EL_MULTIPLIER: rdata_next = mult_reg;
                        `BTOF_EL_FS_MODE: rdata_next = mode_reg;
                        `BTOF_EL_FS_LEVEL: rdata_next = level_reg;
                        default: rdata_next = 8'h00;
                    endcase
                end
            end
        end
    end

    // Configuration and read registers.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            index_reg <= `BTOF_RST_INDEX;
            tbase_reg <= `BTOF_RST_TIME_BASE;
            mult_reg <= `BTOF_RST_MULTIPLIER;
            mode_reg <= `BTOF_RST_FS_MODE;
            level_reg <= `BTOF_RST_FS_LEVEL;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            index_reg <= index_next;
            tbase_reg <= tbase_next;
            mult_reg <= mult_next;
            mode_reg <= mode_next;
            level_reg <= level_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign reg_rvalid_o = rvalid_reg;

    // Watchdog state.
    btof_pkg::btof_state_t state_reg, state_next;
    logic [TICK_W-1:0] div_reg, div_next;
    logic [16:0] ms_reg, ms_next;
    logic [15:0] threshold;
    logic enabled;
    logic ms_tick;
    logic trip;
    logic flag_reg, flag_next;
    logic [7:0] outs_reg, outs_next;
    logic [7:0] err_code;
    logic err_push;

    assign threshold = tbase_reg * mult_reg;
    assign enabled = (tbase_reg != 8'h00) && (mult_reg != 8'h00);
    assign ms_tick = (div_reg == TICK_W'(MS_CYCLES - 1));

    // Millisecond divider and gap counter; both restart on bus traffic.
    always_comb begin
        div_next = ms_tick ? '0 : div_reg + 1'b1;
        ms_next = ms_reg;
        if (ms_tick && (ms_reg != 17'h1FFFF)) begin
            ms_next = ms_reg + 17'h00001;
        end
        if (bus_access || !enabled) begin
            div_next = '0;
            ms_next = 17'h00000;
        end
    end

    // Trip when the elapsed gap exceeds the threshold.
    always_comb begin
        trip = 1'b0;
        state_next = state_reg;
        case (state_reg)
            btof_pkg::BTOF_ST_OFF: begin
                if (enabled) begin
                    state_next = btof_pkg::BTOF_ST_WATCH;
                end
            end
            btof_pkg::BTOF_ST_WATCH: begin
                if (!enabled) begin
                    state_next = btof_pkg::BTOF_ST_OFF;
                end else if (!bus_access && (ms_reg > {1'b0, threshold})) begin
                    trip = 1'b1;
                    state_next = btof_pkg::BTOF_ST_TRIPPED;
                end
            end
            btof_pkg::BTOF_ST_TRIPPED: begin
                if (bus_access) begin
                    state_next = enabled ? btof_pkg::BTOF_ST_WATCH : btof_pkg::BTOF_ST_OFF;
                end
            end
            default: state_next = btof_pkg::BTOF_ST_OFF;
        endcase
    end

    // Timeout flag: a trip sets it, traffic clears it, and the set wins.
    always_comb begin
        flag_next = flag_reg;
        if (bus_access) begin
            flag_next = 1'b0;
        end
        if (trip) begin
            flag_next = 1'b1;
        end
    end

    // Outputs follow requests until a timeout, then freeze or take the failsafe level per bit.
    always_comb begin
        outs_next = out_req_i;
        if (state_reg == btof_pkg::BTOF_ST_TRIPPED || trip) begin
            outs_next = (mode_reg & level_reg) | (~mode_reg & outs_reg);
        end
    end

    // Watchdog registers.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= btof_pkg::BTOF_ST_OFF;
            div_reg <= '0;
            ms_reg <= 17'h00000;
            flag_reg <= 1'b0;
            outs_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            div_reg <= div_next;
            ms_reg <= ms_next;
            flag_reg <= flag_next;
            outs_reg <= outs_next;
        end
    end

    assign out_o = outs_reg;
    assign comm_timeout_o = flag_reg;

    // Bit-coded error code; reserved bits stay zero.
    always_comb begin
        err_code = 8'h00;
        err_code[`BTOF_ERR_OUTPUT_BIT] = err_output_fault_i;
        err_code[`BTOF_ERR_TIMEOUT_BIT] = trip;
        err_code[`BTOF_ERR_OVERFLOW_BIT] = err_buf_overflow_i;
    end

    assign err_push = (err_code != 8'h00);

    // Remanent error history.
    btof_history u_hist (
        .ref_clk_i(ref_clk_i),
        .lifetime_init_i(lifetime_init_i),
        .push_i(err_push),
        .code_i(err_code),
        .rd_sel_i(hist_sel),
        .rd_data_o(hist_rd)
    );

endmodule

// ===== design/btof_defs.svh
`ifndef BTOF_DEFS_SVH
`define BTOF_DEFS_SVH

// Register numbers on the module register port.
`define BTOF_REG_INDEX 4'h8
`define BTOF_REG_VALUE 4'h9

// Array element indices.
`define BTOF_EL_TIME_BASE 8'h04
`define BTOF_EL_MULTIPLIER 8'h05
`define BTOF_EL_HIST_FIRST 8'h0A
`define BTOF_EL_HIST_LAST 8'h13
`define BTOF_EL_FS_MODE 8'h32
`define BTOF_EL_FS_LEVEL 8'h33

// Reset values.
`define BTOF_RST_TIME_BASE 8'h00
`define BTOF_RST_MULTIPLIER 8'h00
`define BTOF_RST_FS_MODE 8'h00
`define BTOF_RST_FS_LEVEL 8'h00
`define BTOF_RST_INDEX 8'h00

// Error code bit positions.
`define BTOF_ERR_OUTPUT_BIT 1
`define BTOF_ERR_TIMEOUT_BIT 2
`define BTOF_ERR_OVERFLOW_BIT 7

// History depth.
`define BTOF_HIST_DEPTH 10

// Timing: clock period and millisecond time base.
`define BTOF_CLK_PERIOD_NS 10
`define BTOF_MS_TIME_NS 1000000
`define BTOF_MS_CYCLES (`BTOF_MS_TIME_NS / `BTOF_CLK_PERIOD_NS)

`endif

// ===== design/btof_pkg.sv
package btof_pkg;

    // Watchdog states, one-hot.
    typedef enum logic [2:0] {
        BTOF_ST_OFF = 3'b001,
        BTOF_ST_WATCH = 3'b010,
        BTOF_ST_TRIPPED = 3'b100
    } btof_state_t;

    typedef logic [7:0] btof_byte_t;

endpackage

// ===== design/btof_history.sv
`include "btof_defs.svh"

module btof_history (
    // Clock and lifetime initialisation.
    input wire logic ref_clk_i,
    input wire logic lifetime_init_i,
    // Recording side.
    input wire logic push_i,
    input wire logic [7:0] code_i,
    // Read side.
    input wire logic [3:0] rd_sel_i,
    output logic [7:0] rd_data_o
);

    logic [7:0] hist_reg [`BTOF_HIST_DEPTH];
    logic [7:0] hist_next [`BTOF_HIST_DEPTH];
    logic [7:0] shift_in [`BTOF_HIST_DEPTH];

    // Entry 0 is the newest code; a push moves every entry one place older.
    genvar g;
    generate
        for (g = 0; g < `BTOF_HIST_DEPTH; g++) begin : g_ent
            // The newest slot takes the new code, the others take their younger neighbour.
            if (g == 0) begin : g_new
                assign shift_in[g] = code_i;
            end else begin : g_old
                assign shift_in[g] = hist_reg[g-1];
            end

            // A push loads the shifted value; otherwise the entry holds.
            always_comb begin
                hist_next[g] = hist_reg[g];
                if (push_i) begin
                    hist_next[g] = shift_in[g];
                end
            end

            // Storage is remanent: only the lifetime initialisation clears it, never rst_i.
            always_ff @(posedge ref_clk_i or posedge lifetime_init_i) begin
                if (lifetime_init_i) begin
                    hist_reg[g] <= 8'h00;
                end else begin
                    hist_reg[g] <= hist_next[g];
                end
            end
        end
    endgenerate

    // Combinational read port; out-of-range selects read zero.
    always_comb begin
        rd_data_o = 8'h00;
        if (rd_sel_i < 4'(`BTOF_HIST_DEPTH)) begin
            rd_data_o = hist_reg[rd_sel_i];
        end
    end

endmodule

// ===== tb/btof_watchdog_sva.sv
module btof_watchdog_sva #(
    parameter int MS_CYCLES = 4
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Register port.
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    // Output path.
    input wire logic [7:0] out_req_i,
    input wire logic [7:0] out_o,
    input wire logic comm_timeout_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] idle_reg;
    logic acc;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Any strobe, mapped or not, counts as controller traffic.
    assign acc = reg_wr_i | reg_rd_i;
    // Quiet cycles since the last access, saturating.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            idle_reg <= 20'h0;
        end else begin
            idle_reg <= acc ? 20'h0 : idle_reg + {19'h0, ~&idle_reg};
        end
    end
    // Each assertion ties an output to its cause at the inputs.
    rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
    no_spurious_a: assert property (!reg_rd_i |=> !reg_rvalid_o) else $error("answer without read");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
    unmapped_zero_a: assert property (reg_rd_i && reg_addr_i != 4'h8 && reg_addr_i != 4'h9
        |=> reg_rdata_o == 8'h00) else $error("unmapped register not zero");
    access_clear_a: assert property (acc |=> !comm_timeout_o) else $error("flag survived access");
    trip_hold_a: assert property (comm_timeout_o && !acc |=> comm_timeout_o) else $error("flag dropped");
    trip_gap_a: assert property ($rose(comm_timeout_o) |-> idle_reg >= 2 * MS_CYCLES)
        else $error("trip after too short a gap");
    out_follow_a: assert property (!comm_timeout_o && !$past(comm_timeout_o) && !$past(rst_i)
        |-> out_o == $past(out_req_i)) else $error("outputs not following request");
    out_freeze_a: assert property (comm_timeout_o && $past(comm_timeout_o) |-> $stable(out_o))
        else $error("outputs moved while tripped");
endmodule

bind btof_watchdog btof_watchdog_sva #(.MS_CYCLES(MS_CYCLES)) chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .out_req_i(out_req_i), .out_o(out_o), .comm_timeout_o(comm_timeout_o)
);

// ===== tb/btof_ctl_model.sv
`include "btof_defs.svh"

module btof_ctl_model (
    // Clock.
    input wire logic ref_clk_i,
    // Register port towards the watchdog.
    output logic [3:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus is quiet at start.
    initial begin
        reg_addr_o = 4'h0;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // One strobe cycle; released data is inverted so a stale value is never mistaken.
    task automatic xfer(input logic [3:0] a, input logic w, input logic [7:0] d, output logic [8:0] v);
        @(negedge ref_clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = w;
        reg_rd_o = ~w;
        @(negedge ref_clk_i);
        v = {reg_rvalid_i, reg_rdata_i};
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = ~reg_wdata_o;
    endtask
    // Element write: index first, then value.
    task automatic put(input logic [7:0] el, input logic [7:0] d);
        logic [8:0] v;
        xfer(`BTOF_REG_INDEX, 1'b1, el, v);
        xfer(`BTOF_REG_VALUE, 1'b1, d, v);
    endtask
    // Element read: index first, then value with its answer flag.
    task automatic get(input logic [7:0] el, output logic [8:0] v);
        xfer(`BTOF_REG_INDEX, 1'b1, el, v);
        xfer(`BTOF_REG_VALUE, 1'b0, 8'h00, v);
    endtask
endmodule

// ===== tb/tb_bus_timeout_output_failsafe.sv
module tb_bus_timeout_output_failsafe;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 4;
    logic ref_clk_i, rst_i, life, wr, rd, flt, ovf, tmo, rvalid;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, req, out;
    logic [8:0] v;
    int num_errors, total_checks, n;
    // Rows: element, value written, value read back.
    logic [23:0] rows [6] = '{24'h045A5A, 24'h05A5A5, 24'h323C3C, 24'h33C3C3, 24'h0A5500, 24'h207700};
    logic [7:0] hist [4] = '{8'h82, 8'h80, 8'h02, 8'h04};

    btof_watchdog #(.MS_CYCLES(MS)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .lifetime_init_i(life),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .err_output_fault_i(flt), .err_buf_overflow_i(ovf), .out_req_i(req),
        .out_o(out), .comm_timeout_o(tmo));
    btof_ctl_model ctl (.ref_clk_i(ref_clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

    // Compares one value and counts it.
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic results();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One-cycle error event pulses.
    task automatic pulse(input logic f, input logic o);
        @(negedge ref_clk_i);
        flt = f;
        ovf = o;
        @(negedge ref_clk_i);
        flt = 1'b0;
        ovf = 1'b0;
    endtask

    // Free-running clock.
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // Main sequence.
    initial begin
        num_errors = 0;
        total_checks = 0;
        rst_i = 1'b1;
        life = 1'b1;
        flt = 1'b0;
        ovf = 1'b0;
        req = 8'hA5;
        repeat (8) @(negedge ref_clk_i);
        rst_i = 1'b0;
        life = 1'b0;
        foreach (rows[i]) begin
            ctl.get(rows[i][23:16], v);
            chk(v, 9'h100);
            ctl.put(rows[i][23:16], rows[i][15:8]);
            ctl.get(rows[i][23:16], v);
            chk(v, {1'b1, rows[i][7:0]});
        end
        ctl.xfer(4'h3, 1'b0, 8'h00, v);
        chk(v, 9'h100);
        // The index register reads back the last element number written.
        ctl.xfer(4'h8, 1'b0, 8'h00, v);
        chk(v, 9'h120);
        // A zero time base must never trip.
        ctl.put(8'h04, 8'h00);
        repeat (2000) @(negedge ref_clk_i);
        chk({8'h00, tmo}, 9'h000);
        // Threshold of 210 ms, then stay quiet.
        ctl.put(8'h04, 8'h0F);
        ctl.put(8'h05, 8'h0E);
        n = 0;
        while (tmo !== 1'b1 && n < 2000) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk({8'h00, n >= 842 && n <= 850}, 9'h001);
        if (tmo !== 1'b1) begin
            results();
        end
        req = 8'h0F;
        repeat (3) @(negedge ref_clk_i);
        chk({tmo, out}, {1'b1, (8'hC3 & 8'h3C) | (8'hA5 & ~8'h3C)});
        ctl.get(8'h0A, v);
        chk(v, 9'h104);
        chk({tmo, out}, 9'h00F);
        // Error events, two of them merged in one cycle.
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b1);
        pulse(1'b1, 1'b1);
        foreach (hist[i]) begin
            ctl.get(8'(8'h0A + i), v);
            chk(v, {1'b1, hist[i]});
        end
        repeat (6) pulse(1'b0, 1'b1);
        ctl.get(8'h13, v);
        chk(v, 9'h104);
        pulse(1'b0, 1'b1);
        ctl.get(8'h13, v);
        chk(v, 9'h102);
        // Reset in mid-run keeps the history.
        @(negedge ref_clk_i);
        rst_i = 1'b1;
        @(negedge ref_clk_i);
        chk({tmo, out}, 9'h000);
        rst_i = 1'b0;
        ctl.get(8'h13, v);
        chk(v, 9'h102);
        ctl.get(8'h05, v);
        chk(v, 9'h100);
        // A zero multiplier alone must also keep the watchdog quiet.
        ctl.put(8'h04, 8'h0F);
        repeat (1000) @(negedge ref_clk_i);
        chk({8'h00, tmo}, 9'h000);
        results();
    end
endmodule
